// file: hdl/gpio_wake_pkg.sv
// constants, register map and types for the gpio wake, system-interrupt and led block
package gpio_wake_pkg;
    localparam int PIN_COUNT = 38;
    // pin vector layout
    localparam int PIN_P1 = 0;
    localparam int PIN_P2 = 8;
    localparam int PIN_P3 = 16;
    localparam int PIN_P4 = 24;
    localparam int PIN_P5 = 28;
    localparam int PIN_P6 = 36;
    localparam int DUAL_COUNT = 6;
    localparam int DUAL_PIN [DUAL_COUNT] = '{9, 10, 25, 27, 36, 37};
    localparam int PIN_P3_3 = 19;

    // register map
    localparam logic [7:0] ADDR_WAKE_STS_BASE = 8'h30;
    localparam logic [7:0] ADDR_WAKE_EN_BASE = 8'h38;
    localparam logic [7:0] ADDR_INTR_STS_BASE = 8'h40;
    localparam logic [7:0] ADDR_INTR_EN_BASE = 8'h48;
    localparam logic [7:0] ADDR_MISC_STS = 8'h58;
    localparam logic [7:0] ADDR_CTRL = 8'h59;
    localparam logic [7:0] ADDR_LED_ONE = 8'h5D;
    localparam logic [7:0] ADDR_LED_TWO = 8'h5E;
    localparam logic [7:0] WAKE_SET_MASK = 8'hBC;
    localparam logic [7:0] INTR_SET_MASK = 8'hF8;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // control register fields
    localparam int CTRL_WAKE_GLOBAL_EN = 0;
    localparam int CTRL_SYS_INTR_PIN_EN = 1;
    localparam int CTRL_P4_3_ALT = 2;

    // led blink timing on the 32 kHz clock
    localparam int SLOW_CLK_HZ = 32768;
    localparam int LED_HALF_PERIOD_MS = 500;
    localparam int LED_HALF_TICKS = SLOW_CLK_HZ * LED_HALF_PERIOD_MS / 1000;

    typedef enum logic [1:0] {LED_OFF, LED_ON, LED_BLINK, LED_BLINK_ALT} led_mode_t;
endpackage

// file: hdl/led_ctl_if.sv
// carrier between the register side and one led driver
`timescale 1ns/100ps
interface led_ctl_if;
    logic [1:0] mode;
    logic tick;
    logic lit;
    modport ctl (output mode, output tick, input lit);
    modport drv (input mode, input tick, output lit);
endinterface

// file: hdl/pin_edge_detect.sv
// synchroniser and polarity or either-edge event detector for a bank of pins
`timescale 1ns/100ps
module pin_edge_detect #(
    parameter int WIDTH = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic [WIDTH-1:0] i_pins,
    input wire logic [WIDTH-1:0] i_polarity,
    input wire logic [WIDTH-1:0] i_either_edge,
    output logic [WIDTH-1:0] o_level,
    output logic [WIDTH-1:0] o_event
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] prev_ff;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] fall;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            meta_ff <= '0;
            sync_ff <= '0;
            prev_ff <= '0;
        end else begin
            meta_ff <= i_pins;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign rise = sync_ff & ~prev_ff;
    assign fall = ~sync_ff & prev_ff;
    assign o_level = sync_ff;

    assign o_event = (i_either_edge & (rise | fall)) | (~i_either_edge & ((~i_polarity & rise) | (i_polarity & fall)));
endmodule

// file: hdl/led_driver.sv
// one led: off, on or blink paced by ticks of the slow clock
`timescale 1ns/100ps
module led_driver import gpio_wake_pkg::*; #(
    parameter int HALF_TICKS = LED_HALF_TICKS
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    led_ctl_if.drv ctl
);
    localparam int CW = $clog2(HALF_TICKS + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF_TICKS - 1);
    logic [CW-1:0] cnt_ff;
    logic phase_ff;
    logic lit_ff;
    led_mode_t mode;

    assign mode = led_mode_t'(ctl.mode);

    // blink advances only on slow ticks
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            cnt_ff <= '0;
            phase_ff <= 1'b0;
        end else if (mode == LED_OFF || mode == LED_ON) begin
            cnt_ff <= '0;
            phase_ff <= 1'b0;
        end else if (ctl.tick) begin
            if (cnt_ff == LAST) begin
                cnt_ff <= '0;
                phase_ff <= ~phase_ff;
            end else begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            lit_ff <= 1'b0;
        end else begin
            unique case (mode)
                LED_OFF: lit_ff <= 1'b0;
                LED_ON: lit_ff <= 1'b1;
                LED_BLINK, LED_BLINK_ALT: lit_ff <= ~phase_ff;
            endcase
        end
    end

    assign ctl.lit = lit_ff;
endmodule

// file: hdl/gpio_wake_event_led.sv
// gpio wake and system-interrupt event status, enables, outputs and led control
`timescale 1ns/100ps
module gpio_wake_event_led import gpio_wake_pkg::*; #(
    parameter int BLINK_HALF_TICKS = LED_HALF_TICKS
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic [PIN_COUNT-1:0] i_gpio_pins,
    input wire logic [PIN_COUNT-1:0] i_gpio_polarity,
    input wire logic [DUAL_COUNT-1:0] i_either_edge_trigger,
    input wire logic i_main_power_off,
    input wire logic i_slow_clk,
    input wire logic i_port3_pin3_data,
    output logic [DUAL_COUNT-1:0] o_dual_data,
    output logic o_wake_output_n,
    output logic o_wake_output_oe_n,
    output logic o_sys_intr_output_n,
    output logic o_sys_intr_output_oe_n,
    output logic o_port3_pin3_out,
    output logic o_port3_pin3_oe_n,
    output logic o_port4_pin3_gpio_sel,
    output logic [1:0] o_led
);
    ////////////////////////////////////////////////////////////////////////////////
    // pin events
    logic [PIN_COUNT-1:0] dual_sel;
    logic [PIN_COUNT-1:0] eff_polarity;
    logic [PIN_COUNT-1:0] pin_level;
    logic [PIN_COUNT-1:0] pin_event;
    logic [PIN_COUNT-1:0] ev;
    logic main_off_meta_ff;
    logic main_off_ff;
    logic slow_meta_ff;
    logic slow_sync_ff;
    logic slow_prev_ff;
    logic slow_tick;

    always_comb begin
        dual_sel = '0;
        for (int k = 0; k < DUAL_COUNT; k++) begin
            dual_sel[DUAL_PIN[k]] = i_either_edge_trigger[k];
        end
    end

    assign eff_polarity = i_gpio_polarity & ~dual_sel;

    pin_edge_detect #(
        .WIDTH(PIN_COUNT)
    ) u_edges (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_pins(i_gpio_pins),
        .i_polarity(eff_polarity),
        .i_either_edge(dual_sel),
        .o_level(pin_level),
        .o_event(pin_event)
    );

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            main_off_meta_ff <= 1'b0;
            main_off_ff <= 1'b0;
            slow_meta_ff <= 1'b0;
            slow_sync_ff <= 1'b0;
            slow_prev_ff <= 1'b0;
        end else begin
            main_off_meta_ff <= i_main_power_off;
            main_off_ff <= main_off_meta_ff;
            slow_meta_ff <= i_slow_clk;
            slow_sync_ff <= slow_meta_ff;
            slow_prev_ff <= slow_sync_ff;
        end
    end

    assign slow_tick = slow_sync_ff & ~slow_prev_ff;

    always_comb begin
        ev = pin_event;
        ev[PIN_P3_3] = pin_event[PIN_P3_3] & ~main_off_ff;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // event routing into status sets
    logic [7:0] wake_ev [8];
    logic [7:0] intr_ev [8];
    logic [DUAL_COUNT-1:0] misc_ev;

    // one wake and one intr bit per pin
    // port4 pins 0 and 2 and port2 pin3 unrouted
    always_comb begin
        for (int s = 0; s < 8; s++) begin
            wake_ev[s] = 8'h00;
            intr_ev[s] = 8'h00;
        end
        wake_ev[2] = ev[PIN_P1 +: 8];
        wake_ev[3] = {ev[PIN_P2 + 4 +: 4], 1'b0, ev[PIN_P2 +: 3]};
        wake_ev[4] = {ev[PIN_P6 + 1], ev[PIN_P6], ev[PIN_P4 + 3], ev[PIN_P4 + 1], ev[PIN_P3 +: 4]};
        wake_ev[5] = ev[PIN_P5 +: 8];
        wake_ev[7] = {4'h0, ev[PIN_P3 + 4 +: 4]};
        intr_ev[3] = {ev[PIN_P2 + 4 +: 4], ev[PIN_P6], ev[PIN_P2 +: 3]};
        intr_ev[4] = {1'b0, ev[PIN_P6 + 1], ev[PIN_P4 + 3], ev[PIN_P4 + 1], ev[PIN_P3 +: 4]};
        intr_ev[5] = ev[PIN_P5 +: 8];
        intr_ev[6] = ev[PIN_P1 +: 8];
        intr_ev[7] = {4'h0, ev[PIN_P3 + 4 +: 4]};
    end

    // misc gathers the six either-edge pins
    always_comb begin
        for (int k = 0; k < DUAL_COUNT; k++) begin
            misc_ev[k] = ev[DUAL_PIN[k]];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register decode
    logic wr_wake_sts;
    logic wr_wake_en;
    logic wr_intr_sts;
    logic wr_intr_en;
    logic [2:0] set_idx;

    assign set_idx = i_reg_addr[2:0];
    assign wr_wake_sts = i_reg_wr && (i_reg_addr & 8'hF8) == ADDR_WAKE_STS_BASE && WAKE_SET_MASK[set_idx];
    assign wr_wake_en = i_reg_wr && (i_reg_addr & 8'hF8) == ADDR_WAKE_EN_BASE && WAKE_SET_MASK[set_idx];
    assign wr_intr_sts = i_reg_wr && (i_reg_addr & 8'hF8) == ADDR_INTR_STS_BASE && INTR_SET_MASK[set_idx];
    assign wr_intr_en = i_reg_wr && (i_reg_addr & 8'hF8) == ADDR_INTR_EN_BASE && INTR_SET_MASK[set_idx];

    ////////////////////////////////////////////////////////////////////////////////
    // status and enable registers
    logic [7:0] wake_sts_ff [8];
    logic [7:0] wake_en_ff [8];
    logic [7:0] intr_sts_ff [8];
    logic [7:0] intr_en_ff [8];
    logic [DUAL_COUNT-1:0] misc_sts_ff;
    logic [7:0] ctrl_ff;
    logic [7:0] led_one_ff;
    logic [7:0] led_two_ff;

    // write one clears, new event wins
    always_ff @(posedge i_sys_clk) begin
        for (int s = 0; s < 8; s++) begin
            if (i_reset) begin
                wake_sts_ff[s] <= RESET_BYTE;
            end else begin
                wake_sts_ff[s] <= (wake_sts_ff[s] & ~((wr_wake_sts && set_idx == s) ? i_reg_wdata : 8'h00))
                    | (wake_ev[s] & {8{WAKE_SET_MASK[s]}});
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        for (int s = 0; s < 8; s++) begin
            if (i_reset) begin
                intr_sts_ff[s] <= RESET_BYTE;
            end else begin
                intr_sts_ff[s] <= (intr_sts_ff[s] & ~((wr_intr_sts && set_idx == s) ? i_reg_wdata : 8'h00))
                    | (intr_ev[s] & {8{INTR_SET_MASK[s]}});
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            misc_sts_ff <= '0;
        end else if (i_reg_wr && i_reg_addr == ADDR_MISC_STS) begin
            misc_sts_ff <= (misc_sts_ff & ~i_reg_wdata[DUAL_COUNT-1:0]) | misc_ev;
        end else begin
            misc_sts_ff <= misc_sts_ff | misc_ev;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        for (int s = 0; s < 8; s++) begin
            if (i_reset) begin
                wake_en_ff[s] <= RESET_BYTE;
                intr_en_ff[s] <= RESET_BYTE;
            end else begin
                if (wr_wake_en && set_idx == s) begin
                    wake_en_ff[s] <= i_reg_wdata;
                end
                if (wr_intr_en && set_idx == s) begin
                    intr_en_ff[s] <= i_reg_wdata;
                end
            end
        end
    end

    // port4 pin3 back to gpio on reset
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            ctrl_ff <= RESET_BYTE;
            led_one_ff <= RESET_BYTE;
            led_two_ff <= RESET_BYTE;
        end else if (i_reg_wr) begin
            if (i_reg_addr == ADDR_CTRL) begin
                ctrl_ff <= i_reg_wdata;
            end
            if (i_reg_addr == ADDR_LED_ONE) begin
                led_one_ff <= i_reg_wdata;
            end
            if (i_reg_addr == ADDR_LED_TWO) begin
                led_two_ff <= i_reg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path
    logic [7:0] nxt_rdata;
    logic [7:0] rdata_ff;

    always_comb begin
        nxt_rdata = 8'h00;
        if ((i_reg_addr & 8'hF8) == ADDR_WAKE_STS_BASE) begin
            nxt_rdata = wake_sts_ff[set_idx];
        end else if ((i_reg_addr & 8'hF8) == ADDR_WAKE_EN_BASE) begin
            nxt_rdata = wake_en_ff[set_idx];
        end else if ((i_reg_addr & 8'hF8) == ADDR_INTR_STS_BASE) begin
            nxt_rdata = intr_sts_ff[set_idx];
        end else if ((i_reg_addr & 8'hF8) == ADDR_INTR_EN_BASE) begin
            nxt_rdata = intr_en_ff[set_idx];
        end else if (i_reg_addr == ADDR_MISC_STS) begin
            nxt_rdata = {2'b00, misc_sts_ff};
        end else if (i_reg_addr == ADDR_CTRL) begin
            nxt_rdata = ctrl_ff;
        end else if (i_reg_addr == ADDR_LED_ONE) begin
            nxt_rdata = led_one_ff;
        end else if (i_reg_addr == ADDR_LED_TWO) begin
            nxt_rdata = led_two_ff;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= i_reg_rd ? nxt_rdata : 8'h00;
        end
    end

    assign o_reg_rdata = rdata_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // wake and system-interrupt outputs
    logic wake_any;
    logic intr_any;
    logic wake_oe_n_ff;
    logic intr_oe_n_ff;
    logic [DUAL_COUNT-1:0] dual_data_ff;

    // status and pin enable, global enable on wake only
    always_comb begin
        wake_any = 1'b0;
        intr_any = 1'b0;
        for (int s = 0; s < 8; s++) begin
            wake_any = wake_any | (|(wake_sts_ff[s] & wake_en_ff[s]));
            intr_any = intr_any | (|(intr_sts_ff[s] & intr_en_ff[s]));
        end
        wake_any = wake_any & ctrl_ff[CTRL_WAKE_GLOBAL_EN];
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            wake_oe_n_ff <= 1'b1;
            intr_oe_n_ff <= 1'b1;
        end else begin
            wake_oe_n_ff <= ~wake_any;
            intr_oe_n_ff <= ~(intr_any & ctrl_ff[CTRL_SYS_INTR_PIN_EN]);
        end
    end

    assign o_wake_output_n = 1'b0;
    assign o_wake_output_oe_n = wake_oe_n_ff;
    assign o_sys_intr_output_n = 1'b0;
    assign o_sys_intr_output_oe_n = intr_oe_n_ff;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            dual_data_ff <= '0;
        end else begin
            for (int k = 0; k < DUAL_COUNT; k++) begin
                dual_data_ff[k] <= pin_level[DUAL_PIN[k]] ^ i_gpio_polarity[DUAL_PIN[k]];
            end
        end
    end

    assign o_dual_data = dual_data_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // port3 pin3 and port4 pin3
    logic p33_out_ff;
    logic p43_gpio_ff;

    // low after reset, plain output on standby
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            p33_out_ff <= 1'b0;
        end else if (main_off_ff) begin
            p33_out_ff <= i_port3_pin3_data;
        end else begin
            p33_out_ff <= i_port3_pin3_data ^ i_gpio_polarity[PIN_P3_3];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            p43_gpio_ff <= 1'b1;
        end else begin
            p43_gpio_ff <= ~ctrl_ff[CTRL_P4_3_ALT];
        end
    end

    assign o_port3_pin3_out = p33_out_ff;
    assign o_port3_pin3_oe_n = 1'b0;
    assign o_port4_pin3_gpio_sel = p43_gpio_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // leds
    led_ctl_if led_one_if ();
    led_ctl_if led_two_if ();
    logic [1:0] led_ff;

    assign led_one_if.mode = led_one_ff[1:0];
    assign led_one_if.tick = slow_tick;
    assign led_two_if.mode = led_two_ff[1:0];
    assign led_two_if.tick = slow_tick;

    led_driver #(
        .HALF_TICKS(BLINK_HALF_TICKS)
    ) u_led_one (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .ctl(led_one_if.drv)
    );

    led_driver #(
        .HALF_TICKS(BLINK_HALF_TICKS)
    ) u_led_two (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .ctl(led_two_if.drv)
    );

    // each led from its own register
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            led_ff <= 2'b00;
        end else begin
            led_ff <= {led_two_if.lit, led_one_if.lit};
        end
    end

    assign o_led = led_ff;
endmodule

// file: tb/gpio_wake_monitor.sv
// port checker for the gpio wake, system-interrupt and led block
`timescale 1ns/100ps
module gpio_wake_monitor import gpio_wake_pkg::*; (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [PIN_COUNT-1:0] i_gpio_pins,
    input wire logic [PIN_COUNT-1:0] i_gpio_polarity,
    input wire logic [7:0] o_reg_rdata,
    input wire logic [DUAL_COUNT-1:0] o_dual_data,
    input wire logic o_wake_output_n,
    input wire logic o_wake_output_oe_n,
    input wire logic o_sys_intr_output_n,
    input wire logic o_sys_intr_output_oe_n,
    input wire logic o_port3_pin3_out,
    input wire logic o_port3_pin3_oe_n,
    input wire logic o_port4_pin3_gpio_sel,
    input wire logic [1:0] o_led
);
    logic [DUAL_COUNT-1:0] dual_exp;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);
    always_comb begin
        for (int k = 0; k < DUAL_COUNT; k++) begin
            dual_exp[k] = i_gpio_pins[DUAL_PIN[k]] ^ i_gpio_polarity[DUAL_PIN[k]];
        end
    end
    sequence quiet_pins;
        ($stable(i_gpio_pins) && $stable(i_gpio_polarity)) [*5];
    endsequence
    sequence output_released;
        $rose(o_wake_output_oe_n) || $rose(o_sys_intr_output_oe_n);
    endsequence
    a_rdata_idle_zero: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_open_drain_fixed: assert property (!o_wake_output_n && !o_sys_intr_output_n && !o_port3_pin3_oe_n)
        else $error("open-drain value or port3 pin3 drive wrong");
    a_gpio_sel_reset: assert property ($past(i_reset) |-> o_port4_pin3_gpio_sel)
        else $error("port4 pin3 not gpio after reset");
    a_p33_reset_low: assert property ($past(i_reset) |-> !o_port3_pin3_out)
        else $error("port3 pin3 not low after reset");
    a_led_reset_off: assert property ($past(i_reset) |-> o_led == 2'b00)
        else $error("led lit after reset");
    a_out_reset_float: assert property ($past(i_reset) |-> o_wake_output_oe_n && o_sys_intr_output_oe_n)
        else $error("wake or intr output driven after reset");
    a_dual_readback: assert property (quiet_pins |-> o_dual_data == dual_exp)
        else $error("either-edge data bits not pin xor polarity");
    a_status_release: assert property (output_released |-> $past(i_reg_wr, 2))
        else $error("wake or intr output released without a write");
endmodule

// file: tb/host_chipset_model.sv
// host chipset side: pulled-up wake and intr lines with sticky seen flags
`timescale 1ns/100ps
module host_chipset_model (
    input wire logic i_sys_clk,
    input wire logic i_clear,
    input wire logic i_wake_n,
    input wire logic i_wake_oe_n,
    input wire logic i_intr_n,
    input wire logic i_intr_oe_n,
    output logic o_wake_seen,
    output logic o_intr_seen
);
    logic wake_line;
    logic intr_line;
    // pull-ups hold released lines high
    assign wake_line = i_wake_oe_n ? 1'b1 : i_wake_n;
    assign intr_line = i_intr_oe_n ? 1'b1 : i_intr_n;
    always_ff @(posedge i_sys_clk) begin
        if (i_clear) begin
            o_wake_seen <= 1'b0;
            o_intr_seen <= 1'b0;
        end else begin
            o_wake_seen <= o_wake_seen | ~wake_line;
            o_intr_seen <= o_intr_seen | ~intr_line;
        end
    end
endmodule

// file: tb/gpio_wake_event_led_test.sv
// self-checking bench for the gpio wake, system-interrupt and led block
`timescale 1ns/100ps
module gpio_wake_event_led_test;
    import gpio_wake_pkg::*;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, main_off = 1'b0, slow = 1'b0, p33 = 1'b0, clr = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [PIN_COUNT-1:0] pins = '0, pol = '0;
    logic [DUAL_COUNT-1:0] dual = '0, dual_d;
    logic wn, woe, sn, soe, p33o, p33oe, sel, wseen, sseen;
    logic [1:0] led;
    int failures = 0, comparisons = 0, cycles = 0;
    always #10 clk = ~clk;
    always #15259 slow = ~slow;
    gpio_wake_event_led #(.BLINK_HALF_TICKS(4)) u_dut (.i_sys_clk(clk), .i_reset(rst), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_gpio_pins(pins),
        .i_gpio_polarity(pol), .i_either_edge_trigger(dual), .i_main_power_off(main_off), .i_slow_clk(slow),
        .i_port3_pin3_data(p33), .o_dual_data(dual_d), .o_wake_output_n(wn), .o_wake_output_oe_n(woe),
        .o_sys_intr_output_n(sn), .o_sys_intr_output_oe_n(soe), .o_port3_pin3_out(p33o),
        .o_port3_pin3_oe_n(p33oe), .o_port4_pin3_gpio_sel(sel), .o_led(led));
    host_chipset_model u_host (.i_sys_clk(clk), .i_clear(clr), .i_wake_n(wn), .i_wake_oe_n(woe),
        .i_intr_n(sn), .i_intr_oe_n(soe), .o_wake_seen(wseen), .o_intr_seen(sseen));
    task automatic results;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            failures++;
            results;
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk($sformatf("reg %h", a), exp, rdata);
        @(posedge clk);
    endtask
    task automatic pulse(input int idx);
        @(posedge clk);
        pins[idx] <= ~pins[idx];
        repeat (5) @(posedge clk);
        pins[idx] <= ~pins[idx];
        repeat (5) @(posedge clk);
    endtask
    task automatic s_reset_map;
        logic [7:0] al [8] = '{8'h30, 8'h32, 8'h37, 8'h40, 8'h46, 8'h58, 8'h59, 8'h5E};
        chk("gpio sel", 8'h01, {7'h0, sel});
        foreach (al[i]) rd_reg(al[i], 8'h00);
        wr_reg(8'h30, 8'hFF);
        rd_reg(8'h30, 8'h00);
    endtask
    task automatic s_pin_map;
        int pn [6] = '{0, 13, 18, 31, 21, 37};
        logic [7:0] wa [6] = '{8'h32, 8'h33, 8'h34, 8'h35, 8'h37, 8'h34};
        logic [7:0] ia [6] = '{8'h46, 8'h43, 8'h44, 8'h45, 8'h47, 8'h44};
        logic [7:0] wm [6] = '{8'h01, 8'h20, 8'h04, 8'h08, 8'h02, 8'h80};
        logic [7:0] im [6] = '{8'h01, 8'h20, 8'h04, 8'h08, 8'h02, 8'h40};
        foreach (pn[i]) begin
            pulse(pn[i]);
            rd_reg(wa[i], wm[i]);
            rd_reg(ia[i], im[i]);
            wr_reg(wa[i], 8'h00);
            rd_reg(wa[i], wm[i]);
            wr_reg(wa[i], wm[i]);
            wr_reg(ia[i], im[i]);
            rd_reg(wa[i], 8'h00);
            rd_reg(ia[i], 8'h00);
        end
        wr_reg(8'h58, 8'hFF);
    endtask
    task automatic s_polarity;
        pol[1] <= 1'b1;
        @(posedge clk);
        pins[1] <= 1'b1;
        repeat (5) @(posedge clk);
        rd_reg(8'h32, 8'h00);
        pins[1] <= 1'b0;
        repeat (5) @(posedge clk);
        rd_reg(8'h32, 8'h02);
        wr_reg(8'h32, 8'h02);
    endtask
    task automatic s_either;
        dual[2] <= 1'b1;
        pol[25] <= 1'b1;
        repeat (6) @(posedge clk);
        wr_reg(8'h34, 8'hFF);
        wr_reg(8'h44, 8'hFF);
        wr_reg(8'h58, 8'hFF);
        wr_reg(8'h4C, 8'h10);
        wr_reg(8'h59, 8'h02);
        for (int e = 0; e < 2; e++) begin
            pins[25] <= ~pins[25];
            repeat (5) @(posedge clk);
            chk("dual data", {7'h0, e[0]}, {7'h0, dual_d[2]});
            chk("intr out", 8'h00, {7'h0, soe});
            rd_reg(8'h58, 8'h04);
            rd_reg(8'h34, 8'h10);
            rd_reg(8'h44, 8'h10);
            wr_reg(8'h58, 8'h04);
            wr_reg(8'h34, 8'h10);
            wr_reg(8'h44, 8'h10);
        end
    endtask
    task automatic s_inert;
        logic [7:0] al [9] = '{8'h32, 8'h33, 8'h34, 8'h35, 8'h37, 8'h43, 8'h44, 8'h45, 8'h47};
        pulse(24);
        pulse(26);
        pulse(11);
        main_off <= 1'b1;
        repeat (3) @(posedge clk);
        pulse(19);
        foreach (al[i]) rd_reg(al[i], 8'h00);
        pulse(0);
        rd_reg(8'h32, 8'h01);
        wr_reg(8'h32, 8'h01);
        wr_reg(8'h46, 8'h01);
    endtask
    task automatic s_p33;
        p33 <= 1'b1;
        pol[19] <= 1'b1;
        main_off <= 1'b0;
        repeat (6) @(posedge clk);
        chk("p33 out", 8'h00, {7'h0, p33o});
        main_off <= 1'b1;
        repeat (6) @(posedge clk);
        chk("p33 out off", 8'h01, {7'h0, p33o});
        main_off <= 1'b0;
    endtask
    task automatic s_outputs;
        // intr enable of port2 pin7 stays clear
        wr_reg(8'h59, 8'h02);
        wr_reg(8'h3A, 8'h01);
        wr_reg(8'h4E, 8'h01);
        for (int g = 0; g < 2; g++) begin
            clr <= 1'b0;
            pulse(0);
            chk("wake seen", {7'h0, g[0]}, {7'h0, wseen});
            chk("intr seen", 8'h01, {7'h0, sseen});
            wr_reg(8'h32, 8'h01);
            wr_reg(8'h46, 8'h01);
            repeat (3) @(posedge clk);
            chk("outputs float", 8'h03, {6'h0, woe, soe});
            clr <= 1'b1;
            wr_reg(8'h59, 8'h03);
        end
        wr_reg(8'h59, 8'h04);
        repeat (3) @(posedge clk);
        chk("gpio sel alt", 8'h00, {7'h0, sel});
    endtask
    task automatic s_led;
        int n;
        wr_reg(8'h5D, 8'h01);
        wr_reg(8'h5E, 8'h00);
        repeat (3) @(posedge clk);
        chk("led on off", 8'h01, {6'h0, led});
        rd_reg(8'h5D, 8'h01);
        main_off <= 1'b1;
        wr_reg(8'h5D, 8'h02);
        wr_reg(8'h5E, 8'h03);
        repeat (3) @(posedge clk);
        chk("blink lit", 8'h03, {6'h0, led});
        for (int ph = 0; ph < 2; ph++) begin
            n = 0;
            while (led !== {2{ph[0]}} && n < 8000) begin
                @(posedge clk);
                n++;
            end
            chk("blink toggle", {6'h0, {2{ph[0]}}}, {6'h0, led});
        end
        main_off <= 1'b0;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        s_reset_map();
        s_pin_map();
        s_polarity();
        s_either();
        s_inert();
        s_p33();
        s_outputs();
        s_led();
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("reset sel led", 8'h04, {5'h0, sel, led});
        results;
    end
endmodule
bind gpio_wake_event_led gpio_wake_monitor u_mon (.i_sys_clk, .i_reset, .i_reg_wr, .i_reg_rd, .i_gpio_pins,
    .i_gpio_polarity, .o_reg_rdata, .o_dual_data, .o_wake_output_n, .o_wake_output_oe_n, .o_sys_intr_output_n,
    .o_sys_intr_output_oe_n, .o_port3_pin3_out, .o_port3_pin3_oe_n, .o_port4_pin3_gpio_sel, .o_led);
